/* common/ecl_cfg.svh */
// Purpose: Constants for the Ethernet stream client
// Assumes: Included by package and design files
// Notes:   Guarded against double inclusion
`ifndef ECL_CFG_SVH
`define ECL_CFG_SVH

// ----------------------------------------------------------------
// Lane layout
// ----------------------------------------------------------------
`define ECL_LANE_BITS   8
`define ECL_PARITY_W    8
`define ECL_DATA_W_DEF  64
`define ECL_DATA_W_NAR  32

// ----------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------
`define ECL_FIFO_DEPTH  32

`endif

/* common/ecl_pkg.sv */
// Purpose: Types for the Ethernet stream client
// Assumes: ecl_cfg.svh holds every number
// Notes:   Types only
`include "ecl_cfg.svh"

package ecl_pkg;

	// ------------------------------------------------------------
	// Transmit sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ECL_TX_IDLE,
		ECL_TX_SEND,
		ECL_TX_FLUSH
	} ecl_tx_state_t;

endpackage : ecl_pkg

/* common/ecl_fifo_if.sv */
// Purpose: Valid/ready word channel between client modules
// Assumes: One clock shared by both ends
// Notes:   Write side fills, read side drains
interface ecl_fifo_if #(
	parameter int W = 74
);
	logic           wr_valid;
	logic           wr_ready;
	logic [W-1:0]   wr_data;
	logic           rd_valid;
	logic           rd_ready;
	logic [W-1:0]   rd_data;

	modport fifo_mp
	(
		input  wr_valid,
		input  wr_data,
		output wr_ready,
		output rd_valid,
		output rd_data,
		input  rd_ready
	);

	modport user_mp
	(
		output wr_valid,
		output wr_data,
		input  wr_ready,
		input  rd_valid,
		input  rd_data,
		output rd_ready
	);
endinterface : ecl_fifo_if

/* rtl/ecl_fifo.sv */
// Purpose: Synchronous word FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, at least 2
// Notes:   Full and empty come from an occupancy count
`include "ecl_cfg.svh"

module ecl_fifo
	import ecl_pkg::*;
#(
	parameter int W     = 74,
	parameter int DEPTH = `ECL_FIFO_DEPTH
)
(
	// Clock and reset
	input  wire logic   clock_i,
	input  wire logic   reset_i,
	// Channel
	ecl_fifo_if.fifo_mp ch
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("ecl_fifo: DEPTH must be a power of two >= 2");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0]   count_q;
	logic          push;
	logic          pop;

	assign ch.wr_ready = (count_q != (AW+1)'(DEPTH));
	assign ch.rd_valid = (count_q != '0);
	assign ch.rd_data  = mem_q[rptr_q];
	assign push        = ch.wr_valid && ch.wr_ready;
	assign pop         = ch.rd_valid && ch.rd_ready;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (push)
			mem_q[wptr_q] <= ch.wr_data;
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wptr_q <= wptr_q + 1'b1;
			if (pop)
				rptr_q <= rptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	fifo_count_a: assert property (@(posedge clock_i) disable iff (reset_i)
		push && !pop |=> count_q == $past(count_q) + 1'b1)
		else $error("fifo count did not rise on push");

	fifo_empty_a: assert property (@(posedge clock_i) disable iff (reset_i)
		pop && !push && count_q == 1 |=> !ch.rd_valid)
		else $error("fifo not empty after last pop");

endmodule // ecl_fifo

/* rtl/ecl_client.sv */
// Purpose: Client that feeds and drains an Ethernet MAC byte stream
// Assumes: MAC stream ports run on clock_i, same-clock logic
// Notes:   Frames pass a 32-word FIFO before the MAC transmit port
//
// Contract
// - Data buses split into 8-bit lanes; keep bit n marks lane n.
// - Client raises transmit valid together with data and keep.
// - Word accepted only with ready high; held unchanged while ready low.
// - Last marks exactly one accepted transfer; keep gives valid bytes.
// - Valid may stay high across frames; MAC may drop ready anytime.
// - New data may appear while ready low, then stays until ready.
// - Abort is user error bit high with last; frame treated errored.
// - MAC never resends aborted frames; client must requeue them. This client only flags them on usr_tx_aborted_o.
// - Receive client accepts a word every cycle; no ready exists.
// - Client discards a frame that ends with user error high. This client passes its words on and raises usr_rx_drop_o.
// - Client drives 8-bit transmit parity, one bit per lane.
`include "ecl_cfg.svh"

module ecl_client
	import ecl_pkg::*;
#(
	parameter int DATA_W = `ECL_DATA_W_DEF,
	parameter int DEPTH  = `ECL_FIFO_DEPTH
)
(
	// Clock and reset
	input  wire logic                  clock_i,
	input  wire logic                  reset_i,
	// User transmit words
	input  wire logic                  usr_tx_valid_i,
	output logic                       usr_tx_ready_o,
	input  wire logic [DATA_W-1:0]     usr_tx_data_i,
	input  wire logic [DATA_W/8-1:0]   usr_tx_keep_i,
	input  wire logic                  usr_tx_last_i,
	input  wire logic                  usr_tx_abort_i,
	// User transmit status
	output logic                       usr_tx_done_o,
	output logic                       usr_tx_aborted_o,
	output logic                       usr_tx_underrun_o,
	// MAC transmit stream
	output logic                       mac_tx_valid_o,
	input  wire logic                  mac_tx_ready_i,
	output logic [DATA_W-1:0]          mac_tx_data_o,
	output logic [DATA_W/8-1:0]        mac_tx_keep_o,
	output logic                       mac_tx_last_o,
	output logic                       mac_tx_user_o,
	output logic [`ECL_PARITY_W-1:0]   mac_tx_parity_o,
	// MAC receive stream
	input  wire logic                  mac_rx_valid_i,
	input  wire logic [DATA_W-1:0]     mac_rx_data_i,
	input  wire logic [DATA_W/8-1:0]   mac_rx_keep_i,
	input  wire logic                  mac_rx_last_i,
	input  wire logic                  mac_rx_user_i,
	input  wire logic [`ECL_PARITY_W-1:0] mac_rx_parity_i,
	// User receive words
	output logic                       usr_rx_valid_o,
	output logic [DATA_W-1:0]          usr_rx_data_o,
	output logic [DATA_W/8-1:0]        usr_rx_keep_o,
	output logic                       usr_rx_last_o,
	output logic                       usr_rx_good_o,
	output logic                       usr_rx_drop_o,
	output logic                       usr_rx_parity_err_o
);
	localparam int KW = DATA_W / `ECL_LANE_BITS;
	localparam int FW = DATA_W + KW + 2;
	localparam int CW = $clog2(DEPTH + 1);

	if (DATA_W != `ECL_DATA_W_DEF && DATA_W != `ECL_DATA_W_NAR)
	begin : g_bad_width
		$error("ecl_client: DATA_W must be 32 or 64");
	end

	// ------------------------------------------------------------
	// Lane parity
	// ------------------------------------------------------------
	logic [`ECL_PARITY_W-1:0] tx_par;
	logic [`ECL_PARITY_W-1:0] rx_par;
	logic [DATA_W-1:0]        tx_next_data;

	for (genvar n = 0; n < `ECL_PARITY_W; n++)
	begin : g_lane
		if (n < KW)
		begin : g_used
			assign tx_par[n] =
				^tx_next_data[n*`ECL_LANE_BITS +: `ECL_LANE_BITS];
			assign rx_par[n] =
				^mac_rx_data_i[n*`ECL_LANE_BITS +: `ECL_LANE_BITS];
		end
		else
		begin : g_unused
			assign tx_par[n] = 1'b0;
			assign rx_par[n] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Transmit FIFO
	// ------------------------------------------------------------
	ecl_fifo_if #(.W(FW)) tx_ch ();

	ecl_fifo #(
		.W     (FW),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.ch      (tx_ch.fifo_mp)
	);

	logic          rd_last;
	logic          rd_abort;
	logic [KW-1:0] rd_keep;

	assign tx_ch.wr_valid = usr_tx_valid_i;
	assign tx_ch.wr_data  = {usr_tx_abort_i, usr_tx_last_i,
	                         usr_tx_keep_i, usr_tx_data_i};
	assign usr_tx_ready_o = tx_ch.wr_ready;
	assign rd_abort       = tx_ch.rd_data[FW-1];
	assign rd_last        = tx_ch.rd_data[FW-2];
	assign rd_keep        = tx_ch.rd_data[DATA_W +: KW];
	assign tx_next_data   = tx_ch.rd_data[DATA_W-1:0];

	// ------------------------------------------------------------
	// Complete frames waiting in the FIFO
	// ------------------------------------------------------------
	logic [CW-1:0] frames_q;
	logic          push_last;
	logic          pop_last;

	assign push_last = tx_ch.wr_valid && tx_ch.wr_ready && usr_tx_last_i;
	assign pop_last  = tx_ch.rd_valid && tx_ch.rd_ready && rd_last;

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			frames_q <= '0;
		else if (push_last && !pop_last)
			frames_q <= frames_q + 1'b1;
		else if (pop_last && !push_last)
			frames_q <= frames_q - 1'b1;
	end

	// ------------------------------------------------------------
	// Transmit sequencer
	// ------------------------------------------------------------
	ecl_tx_state_t state_q;
	logic          in_frame_q;
	logic          accept;
	logic          start;
	logic          underrun;
	logic          load;
	logic          flush;

	// Start only with a whole frame queued, or a full FIFO
	assign start    = (frames_q != '0) || !tx_ch.wr_ready;
	assign accept   = mac_tx_valid_o && mac_tx_ready_i;
	assign underrun = (state_q == ECL_TX_SEND) && in_frame_q
	                  && !mac_tx_valid_o;
	assign load     = tx_ch.rd_valid && (!mac_tx_valid_o || mac_tx_ready_i)
	                  && !underrun
	                  && ((state_q == ECL_TX_SEND)
	                  || (state_q == ECL_TX_IDLE && start));
	assign flush    = (state_q == ECL_TX_FLUSH) && tx_ch.rd_valid;
	assign tx_ch.rd_ready = load || flush;

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			state_q <= ECL_TX_IDLE;
		else
		begin
			case (state_q)
				ECL_TX_IDLE:
					if (load && !rd_last)
						state_q <= ECL_TX_SEND;
				ECL_TX_SEND:
					if (underrun)
						state_q <= ECL_TX_FLUSH;
					else if (load && rd_last)
						state_q <= ECL_TX_IDLE;
				ECL_TX_FLUSH:
					if (flush && rd_last)
						state_q <= ECL_TX_IDLE;
				default:
					state_q <= ECL_TX_IDLE;
			endcase
		end
	end

	// Set by a non-last accepted word, ended by an accepted last
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			in_frame_q <= 1'b0;
		else if (underrun)
			in_frame_q <= 1'b0;
		else if (accept)
			in_frame_q <= !mac_tx_last_o;
	end

	// ------------------------------------------------------------
	// Transmit output stage
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mac_tx_valid_o  <= 1'b0;
			mac_tx_data_o   <= '0;
			mac_tx_keep_o   <= '0;
			mac_tx_last_o   <= 1'b0;
			mac_tx_user_o   <= 1'b0;
			mac_tx_parity_o <= '0;
		end
		else if (load)
		begin
			mac_tx_valid_o  <= 1'b1;
			mac_tx_data_o   <= tx_next_data;
			mac_tx_keep_o   <= rd_keep;
			mac_tx_last_o   <= rd_last;
			mac_tx_user_o   <= rd_abort && rd_last;
			mac_tx_parity_o <= tx_par;
		end
		else if (accept)
			mac_tx_valid_o  <= 1'b0;
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			usr_tx_done_o     <= 1'b0;
			usr_tx_aborted_o  <= 1'b0;
			usr_tx_underrun_o <= 1'b0;
		end
		else
		begin
			usr_tx_done_o     <= accept && mac_tx_last_o;
			usr_tx_aborted_o  <= accept && mac_tx_last_o
			                     && mac_tx_user_o;
			usr_tx_underrun_o <= underrun;
		end
	end

	// ------------------------------------------------------------
	// Receive stage, no back-pressure possible
	// ------------------------------------------------------------
	logic [KW-1:0] rx_bad_lane;

	always_comb
	begin
		rx_bad_lane = mac_rx_keep_i
		              & (mac_rx_parity_i[KW-1:0] ^ rx_par[KW-1:0]);
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			usr_rx_valid_o      <= 1'b0;
			usr_rx_data_o       <= '0;
			usr_rx_keep_o       <= '0;
			usr_rx_last_o       <= 1'b0;
			usr_rx_good_o       <= 1'b0;
			usr_rx_drop_o       <= 1'b0;
			usr_rx_parity_err_o <= 1'b0;
		end
		else
		begin
			usr_rx_valid_o      <= mac_rx_valid_i;
			usr_rx_data_o       <= mac_rx_data_i;
			usr_rx_keep_o       <= mac_rx_keep_i;
			usr_rx_last_o       <= mac_rx_valid_i && mac_rx_last_i;
			usr_rx_good_o       <= mac_rx_valid_i && mac_rx_last_i
			                       && !mac_rx_user_i;
			usr_rx_drop_o       <= mac_rx_valid_i && mac_rx_last_i
			                       && mac_rx_user_i;
			usr_rx_parity_err_o <= mac_rx_valid_i
			                       && (rx_bad_lane != '0);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	tx_hold_stable_a: assert property (@(posedge clock_i) disable iff (reset_i)
		mac_tx_valid_o && !mac_tx_ready_i |=> mac_tx_valid_o
		&& $stable(mac_tx_data_o) && $stable(mac_tx_keep_o)
		&& $stable(mac_tx_last_o))
		else $error("transmit word changed before ready");

	tx_new_data_a: assert property (@(posedge clock_i) disable iff (reset_i)
		$rose(mac_tx_valid_o) && !mac_tx_ready_i ##1 !mac_tx_ready_i
		|-> $stable(mac_tx_data_o) && $stable(mac_tx_user_o))
		else $error("new transmit data moved while ready low");

	tx_parity_a: assert property (@(posedge clock_i) disable iff (reset_i)
		mac_tx_valid_o |-> mac_tx_parity_o[0] == ^mac_tx_data_o[7:0])
		else $error("transmit lane 0 parity wrong");

	tx_abort_last_a: assert property (@(posedge clock_i) disable iff (reset_i)
		mac_tx_valid_o && mac_tx_user_o |-> mac_tx_last_o)
		else $error("transmit abort without last");

	tx_done_pulse_a: assert property (@(posedge clock_i) disable iff (reset_i)
		accept && mac_tx_last_o |=> usr_tx_done_o ##1 (!usr_tx_done_o
		|| ($past(accept) && $past(mac_tx_last_o))))
		else $error("done pulse missing after last");

	tx_underrun_a: assert property (@(posedge clock_i) disable iff (reset_i)
		accept && !mac_tx_last_o ##1 !mac_tx_valid_o
		|=> usr_tx_underrun_o ##1 state_q == ECL_TX_FLUSH
		|| state_q == ECL_TX_IDLE)
		else $error("mid-frame valid drop not reported");

	rx_good_a: assert property (@(posedge clock_i) disable iff (reset_i)
		mac_rx_valid_i && mac_rx_last_i && !mac_rx_user_i
		|=> usr_rx_good_o && !usr_rx_drop_o && usr_rx_last_o)
		else $error("good frame not reported");

	rx_drop_a: assert property (@(posedge clock_i) disable iff (reset_i)
		mac_rx_valid_i && mac_rx_last_i && mac_rx_user_i
		|=> usr_rx_drop_o && !usr_rx_good_o)
		else $error("bad frame not dropped");

	rx_follow_a: assert property (@(posedge clock_i) disable iff (reset_i)
		mac_rx_valid_i |=> usr_rx_valid_o
		&& usr_rx_data_o == $past(mac_rx_data_i))
		else $error("receive word lost");

endmodule // ecl_client

/* bench/ecl_mac_model.sv */
// Purpose: Behavioural MAC stream port facing the client
// Assumes: Transmit and receive streams share clock_i
// Notes:   Ready is the inverse of stall_i; receive frames come from send
module ecl_mac_model
	import ecl_pkg::*;
#(
	parameter int DATA_W = 64
)
(
	// Clock and reset
	input  wire logic                clock_i,
	input  wire logic                reset_i,
	// Stall control
	input  wire logic                stall_i,
	// Transmit stream in
	input  wire logic                tx_valid_i,
	output logic                     tx_ready_o,
	input  wire logic [DATA_W-1:0]   tx_data_i,
	input  wire logic [DATA_W/8-1:0] tx_keep_i,
	input  wire logic                tx_last_i,
	input  wire logic                tx_user_i,
	input  wire logic [7:0]          tx_parity_i,
	// Receive stream out
	output logic                     rx_valid_o = 1'b0,
	output logic [DATA_W-1:0]        rx_data_o = '0,
	output logic [DATA_W/8-1:0]      rx_keep_o = '0,
	output logic                     rx_last_o = 1'b0,
	output logic                     rx_user_o = 1'b0,
	output logic [7:0]               rx_parity_o = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W+17:0] got_q[$];
	logic [DATA_W-1:0]  last_word;
	logic               in_frame;
	int                 underruns;

	assign tx_ready_o = ~stall_i;

	// ------------------------------------------------------------
	// Transmit capture
	// ------------------------------------------------------------
	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			in_frame = 1'b0;
			underruns = 0;
		end
		else if (tx_valid_i && tx_ready_o)
		begin
			got_q.push_back({tx_user_i, tx_last_i, tx_parity_i,
				tx_keep_i, tx_data_i});
			in_frame = !tx_last_i;
		end
		else if (!tx_valid_i && in_frame)
		begin
			underruns++;
			in_frame = 1'b0;
		end
	end

	function automatic logic [7:0] lane_par(logic [DATA_W-1:0] d);
		lane_par = '0;
		for (int i = 0; i < DATA_W / 8; i++)
			lane_par[i] = ^d[8*i +: 8];
	endfunction

	// ------------------------------------------------------------
	// Receive frame generator
	// ------------------------------------------------------------
	task automatic send(input int n, input logic [7:0] lk,
		input logic bad, input logic [7:0] flip);
		logic lst;
		for (int i = 0; i < n; i++)
		begin
			@(negedge clock_i);
			lst = (i == n - 1);
			rx_valid_o = 1'b1;
			rx_data_o = DATA_W'(64'h1122334455667788 * (i + 1));
			rx_keep_o = lst ? lk : '1;
			rx_last_o = lst;
			rx_user_o = lst & bad;
			rx_parity_o = lane_par(rx_data_o) ^ (lst ? flip : 8'h00);
			last_word = rx_data_o;
		end
		@(negedge clock_i);
		rx_valid_o = 1'b0;
		rx_data_o = ~rx_data_o;
		rx_keep_o = ~rx_keep_o;
		rx_last_o = 1'b0;
		rx_user_o = 1'b0;
		rx_parity_o = ~rx_parity_o;
	endtask
endmodule // ecl_mac_model

/* bench/ecl_client_tb.sv */
// Purpose: Self-checking bench for the stream client
// Assumes: 64-bit data, 32-word FIFO, one clock
// Notes:   Inputs change on the falling edge
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	bad_count++; $display("mismatch %s expected %h seen %h", nm, e, g); \
	end end
module ecl_client_tb
	import ecl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DW = 64;
	logic clock_i = 0, reset_i = 1, stall = 1, tv = 0, tl = 0, ta = 0;
	logic [DW-1:0] td = '0;
	logic [7:0] tk = '0;
	logic t_rdy, t_done, t_abt, t_und, m_v, m_r, m_l, m_u, r_v, r_l, r_u;
	logic u_v, u_l, u_g, u_d, u_pe;
	logic [DW-1:0] m_d, r_d, u_dat, last_d;
	logic [7:0] m_k, m_p, r_k, r_p, u_k, last_k;
	int bad_count = 0, checks_done = 0, n_done = 0, n_abt = 0, n_und = 0;
	int n_w = 0, n_g = 0, n_dr = 0, n_pe = 0, n_stray = 0;

	always #50 clock_i = ~clock_i;

	ecl_client #(.DATA_W(DW), .DEPTH(32)) dut (.clock_i(clock_i),
		.reset_i(reset_i), .usr_tx_valid_i(tv), .usr_tx_ready_o(t_rdy),
		.usr_tx_data_i(td), .usr_tx_keep_i(tk), .usr_tx_last_i(tl),
		.usr_tx_abort_i(ta), .usr_tx_done_o(t_done),
		.usr_tx_aborted_o(t_abt), .usr_tx_underrun_o(t_und),
		.mac_tx_valid_o(m_v), .mac_tx_ready_i(m_r), .mac_tx_data_o(m_d),
		.mac_tx_keep_o(m_k), .mac_tx_last_o(m_l), .mac_tx_user_o(m_u),
		.mac_tx_parity_o(m_p), .mac_rx_valid_i(r_v), .mac_rx_data_i(r_d),
		.mac_rx_keep_i(r_k), .mac_rx_last_i(r_l), .mac_rx_user_i(r_u),
		.mac_rx_parity_i(r_p), .usr_rx_valid_o(u_v), .usr_rx_data_o(u_dat),
		.usr_rx_keep_o(u_k), .usr_rx_last_o(u_l), .usr_rx_good_o(u_g),
		.usr_rx_drop_o(u_d), .usr_rx_parity_err_o(u_pe));

	ecl_mac_model #(.DATA_W(DW)) mac (.clock_i(clock_i),
		.reset_i(reset_i), .stall_i(stall), .tx_valid_i(m_v),
		.tx_ready_o(m_r), .tx_data_i(m_d), .tx_keep_i(m_k),
		.tx_last_i(m_l), .tx_user_i(m_u), .tx_parity_i(m_p),
		.rx_valid_o(r_v), .rx_data_o(r_d), .rx_keep_o(r_k),
		.rx_last_o(r_l), .rx_user_o(r_u), .rx_parity_o(r_p));

	// ------------------------------------------------------------
	// Output pulse counters
	// ------------------------------------------------------------
	always @(posedge clock_i)
	begin
		if (!reset_i)
		begin
			if (t_done === 1'b1) n_done++;
			if (t_abt === 1'b1) n_abt++;
			if (t_und === 1'b1) n_und++;
			if (u_v === 1'b1) n_w++;
			if (u_pe === 1'b1) n_pe++;
			if ((u_g === 1'b1 || u_d === 1'b1) && u_l !== 1'b1) n_stray++;
			if (u_v === 1'b1 && u_l === 1'b1)
			begin
				last_k = u_k;
				last_d = u_dat;
				if (u_g === 1'b1) n_g++;
				if (u_d === 1'b1) n_dr++;
			end
		end
	end

	function automatic logic [DW-1:0] wd(int i);
		wd = 64'hF7E6D5C4B3A29180 ^ {8{i[7:0]}};
	endfunction

	function automatic logic [7:0] par(logic [DW-1:0] d);
		for (int i = 0; i < 8; i++)
			par[i] = ^d[8*i +: 8];
	endfunction

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic push(input logic [DW-1:0] d, input logic [7:0] k,
		input logic l, input logic a);
		int n;
		@(negedge clock_i);
		tv = 1'b1; td = d; tk = k; tl = l; ta = a;
		n = 0;
		while (t_rdy !== 1'b1 && n < 100)
		begin
			@(negedge clock_i);
			n++;
		end
		if (n == 100) begin bad_count++; test_done(); end
		@(posedge clock_i);
	endtask

	task automatic idle;
		@(negedge clock_i);
		tv = 1'b0; td = ~td; tk = ~tk; tl = 1'b0; ta = 1'b0;
	endtask

	task automatic wait_q(input int n, input logic tog);
		int c;
		c = 0;
		while (mac.got_q.size() < n && c < 500)
		begin
			@(negedge clock_i);
			stall = tog & ~stall;
			c++;
		end
		stall = 1'b0;
		if (c == 500) begin bad_count++; test_done(); end
		repeat (4) @(negedge clock_i);
	endtask

	task automatic tx_frames;
		int b, d0, a0;
		b = mac.got_q.size(); d0 = n_done; a0 = n_abt;
		stall = 1'b1;
		push(wd(1), 8'hFF, 0, 0);
		push(wd(2), 8'hFF, 0, 0);
		push(wd(3), 8'h07, 1, 1);
		push(wd(4), 8'hFF, 1, 0);
		idle();
		wait_q(b + 4, 1);
		for (int i = 0; i < 4; i++)
			`CHK("tx word", {i == 2, i >= 2, par(wd(i + 1)), (i == 2) ? 8'h07 : 8'hFF, wd(i + 1)}, mac.got_q[b + i])
		`CHK("done and aborted", {32'd2, 32'd1}, {n_done - d0, n_abt - a0})
	endtask

	task automatic fill_drain;
		int b, n, low, u0, m0;
		b = mac.got_q.size(); u0 = n_und; m0 = mac.underruns;
		stall = 1'b1; n = 0; low = 0;
		while (low < 4 && n < 60)
		begin
			@(negedge clock_i);
			tv = t_rdy; td = wd(n); tk = 8'hFF; tl = 1'b0; ta = 1'b0;
			if (tv) begin n++; low = 0; end
			else low++;
		end
		`CHK("fifo full refuses", 2'b10, {n >= 32, t_rdy})
		wait_q(b + n, 0);
		for (int i = 0; i < n; i++)
			`CHK("drained word", wd(i), mac.got_q[b + i][DW-1:0])
		`CHK("underrun", {32'd1, 32'd1}, {n_und - u0, mac.underruns - m0})
		push(wd(99), 8'h01, 1, 0);
		push(wd(50), 8'h03, 1, 0);
		idle();
		wait_q(b + n + 1, 0);
		`CHK("flush then resend", {b + n + 1, 8'h03, wd(50)}, {mac.got_q.size(), mac.got_q[b + n][71:0]})
	endtask

	task automatic rx_case(input int n, input logic [7:0] lk, input logic bad,
		input logic [7:0] flip, input int eg, input int ed, input int ep);
		int w0, g0, d0, p0;
		w0 = n_w; g0 = n_g; d0 = n_dr; p0 = n_pe;
		mac.send(n, lk, bad, flip);
		repeat (3) @(negedge clock_i);
		`CHK("rx counts", {n, eg, ed, ep, 32'd0}, {n_w - w0, n_g - g0, n_dr - d0, n_pe - p0, n_stray})
		`CHK("rx last word", {lk, mac.last_word}, {last_k, last_d})
	endtask

	task automatic rx_frames;
		rx_case(3, 8'h0F, 0, 8'h00, 1, 0, 0);
		rx_case(2, 8'h01, 1, 8'h00, 0, 1, 0);
		rx_case(1, 8'hFF, 0, 8'h04, 1, 0, 1);
		rx_case(1, 8'h03, 0, 8'h80, 1, 0, 0);
	endtask

	initial
	begin
		repeat (2) @(negedge clock_i);
		`CHK("reset outputs", 2'b10, {t_rdy, m_v})
		reset_i = 1'b0;
		tx_frames();
		fill_drain();
		rx_frames();
		test_done();
	end
endmodule // ecl_client_tb
